// >>> rtl/adc_cal_window.sv
/*
 Calibration coefficient access port and first-converter window detector.
 Holds the pointer and data registers for two coefficient sets, the limit
 and control registers, the sticky window flag and the decoded trims.
 Assumes a single-cycle register bus: a read answer appears one cycle
 after the request, and a request is one cycle long.
*/
// Functional notes
// - The offset trim is 14 bits and 0x2000 means no offset change.
// - The gain trim is 13 bits and 0x1000 means unchanged slope.
// - With pointer bit 7 set the index steps after every data access.
// - Pointer bit 6 chooses the first or second converter set.
// - Pointer bits 5 to 0 index the coefficient location.
// - The data register reads and writes the pointed coefficient byte.
// - Every new first-converter result is checked against the window.
// - The window flag is visible for polling and as an interrupt source.
// - Each limit word is two separately written byte registers.
// - Single-ended mode compares the first converter's result word.
// - Differential mode compares the combined result word; the code compares the first converter's result word.
// - Differential mode treats result and limits as two's complement.
// - Low limit above high limit flags results strictly between them.
// - Low limit below high limit flags results outside them.
// - The flag is evaluated at each end of conversion only.
// - The low limit high byte resets to zero.
`timescale 1ns/10ps
module adc_cal_window
    import adc_cal_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire conv_result_t first_result,
    output logic window_hit_flag,
    output logic diff_mode,
    output cal_trim_t first_trim,
    output cal_trim_t second_trim
);
    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    cal_pointer_t ptr_r;
    cal_pointer_t ptr_nxt;
    logic [7:0] gt_low_r;
    logic [7:0] gt_high_r;
    logic [7:0] lt_low_r;
    logic [7:0] lt_high_r;
    logic [7:0] coef_first_r [`COEF_DEPTH];
    logic [7:0] coef_second_r [`COEF_DEPTH];
    logic flag_r;
    logic flag_nxt;
    logic diff_r;
    logic win_hit;

    wire logic wr = sfr_req.en & sfr_req.wr;
    wire logic rd = sfr_req.en & ~sfr_req.wr;
    wire logic sel_ptr = sfr_req.addr == `OFS_CAL_POINTER;
    wire logic sel_data = sfr_req.addr == `OFS_CAL_DATA;
    wire logic sel_gtl = sfr_req.addr == `OFS_HIGH_LIMIT_LOW;
    wire logic sel_gth = sfr_req.addr == `OFS_HIGH_LIMIT_HIGH;
    wire logic sel_ltl = sfr_req.addr == `OFS_LOW_LIMIT_LOW;
    wire logic sel_lth = sfr_req.addr == `OFS_LOW_LIMIT_HIGH;
    wire logic sel_ctrl = sfr_req.addr == `OFS_CONV_CONTROL;
    wire logic data_access = sfr_req.en & sel_data;
    wire logic coef_wr = wr & sel_data;
    wire logic wr_ptr = wr & sel_ptr;
    wire logic wr_gtl = wr & sel_gtl;
    wire logic wr_gth = wr & sel_gth;
    wire logic wr_ltl = wr & sel_ltl;
    wire logic wr_lth = wr & sel_lth;
    wire logic wr_ctrl = wr & sel_ctrl;
    // Only a written zero clears the flag; a written one leaves it alone.
    wire logic flag_clear = wr_ctrl & ~sfr_req.wdata[`CTRL_WIN_BIT];
    wire logic sel_none = ~(sel_ptr | sel_data | sel_gtl | sel_gth | sel_ltl | sel_lth | sel_ctrl);
    wire logic [7:0] coef_sel_rd = ptr_r.converter_set_select ?
        coef_second_r[ptr_r.coefficient_index] : coef_first_r[ptr_r.coefficient_index];
    wire logic [7:0] ctrl_rd = {6'h00, flag_r, diff_r};
    wire logic [7:0] rd_mux = sel_ptr ? ptr_r :
        sel_data ? coef_sel_rd :
        sel_gtl ? gt_low_r :
        sel_gth ? gt_high_r :
        sel_ltl ? lt_low_r :
        sel_lth ? lt_high_r :
        sel_ctrl ? ctrl_rd : 8'h00;

    // ------------------------------------------------------------
    // Pointer register
    // ------------------------------------------------------------
    always_comb begin
        ptr_nxt = ptr_r;
        if (wr && sel_ptr) begin
            ptr_nxt = sfr_req.wdata;
        end else if (data_access && ptr_r.pointer_auto_step) begin
            ptr_nxt.coefficient_index = ptr_r.coefficient_index + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ptr_r <= `PTR_RESET;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Coefficient storage
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < `COEF_DEPTH; i++) begin : g_coef
            wire logic hit_loc = coef_wr && ptr_r.coefficient_index == 6'(i);
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    coef_first_r[i] <= (i == `OFFSET_HIGH_LOC) ? 8'h0020 :
                        (i == `GAIN_HIGH_LOC) ? 8'h0010 : 8'h0000;
                    coef_second_r[i] <= (i == `OFFSET_HIGH_LOC) ? 8'h0020 :
                        (i == `GAIN_HIGH_LOC) ? 8'h0010 : 8'h0000;
                end else begin
                    if (hit_loc && !ptr_r.converter_set_select) begin
                        coef_first_r[i] <= sfr_req.wdata;
                    end
                    if (hit_loc && ptr_r.converter_set_select) begin
                        coef_second_r[i] <= sfr_req.wdata;
                    end
                end
            end
        end
    endgenerate

    // Offset bits 13:8 sit in the low six bits of its second location.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            first_trim <= {`OFFSET_NEUTRAL, `GAIN_NEUTRAL};
            second_trim <= {`OFFSET_NEUTRAL, `GAIN_NEUTRAL};
        end else begin
            first_trim.offset <= {coef_first_r[`OFFSET_HIGH_LOC][5:0],
                coef_first_r[`OFFSET_LOW_LOC]};
            first_trim.gain <= {coef_first_r[`GAIN_HIGH_LOC][4:0],
                coef_first_r[`GAIN_LOW_LOC]};
            second_trim.offset <= {coef_second_r[`OFFSET_HIGH_LOC][5:0],
                coef_second_r[`OFFSET_LOW_LOC]};
            second_trim.gain <= {coef_second_r[`GAIN_HIGH_LOC][4:0],
                coef_second_r[`GAIN_LOW_LOC]};
        end
    end

    // ------------------------------------------------------------
    // Limit and control registers
    // ------------------------------------------------------------
    // Limit bytes land one at a time; a half-written word is compared as it stands.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gt_low_r <= `LIMIT_RESET;
        end else if (wr_gtl) begin
            gt_low_r <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gt_high_r <= `LIMIT_RESET;
        end else if (wr_gth) begin
            gt_high_r <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lt_low_r <= `LIMIT_RESET;
        end else if (wr_ltl) begin
            lt_low_r <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lt_high_r <= `LIMIT_RESET;
        end else if (wr_lth) begin
            lt_high_r <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            diff_r <= 1'b0;
        end else if (wr_ctrl) begin
            diff_r <= sfr_req.wdata[`CTRL_DIFF_BIT];
        end
    end

    // A hit in the cycle of a clearing write wins over the clear.
    always_comb begin
        flag_nxt = flag_r;
        if (flag_clear) begin
            flag_nxt = 1'b0;
        end
        if (win_hit) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            window_hit_flag <= 1'b0;
        end else begin
            window_hit_flag <= flag_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            diff_mode <= 1'b0;
        end else begin
            diff_mode <= diff_r;
        end
    end

    // ------------------------------------------------------------
    // Window comparator
    // ------------------------------------------------------------
    window_compare u_cmp (
        .clk(clk),
        .rst_b(rst_b),
        .diff_mode(diff_r),
        .high_limit({gt_high_r, gt_low_r}),
        .low_limit({lt_high_r, lt_low_r}),
        .result(first_result),
        .hit(win_hit)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_step_on_access: assert property (@(posedge clk) disable iff (!rst_b)
        data_access && ptr_r.pointer_auto_step && !wr_ptr |=>
        ptr_r.coefficient_index == $past(ptr_r.coefficient_index) + 6'h01)
        else $error("pointer did not step after data access");
    a_hold_no_step: assert property (@(posedge clk) disable iff (!rst_b)
        data_access && !ptr_r.pointer_auto_step && !wr_ptr |=>
        $stable(ptr_r))
        else $error("pointer moved with stepping off");
    a_ptr_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ptr |=> ptr_r == $past(sfr_req.wdata))
        else $error("pointer write lost");
    a_ptr_reset: assert property (@(posedge clk)
        !rst_b |=> ptr_r == `PTR_RESET)
        else $error("pointer reset value wrong");
    a_ptr_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd && sel_ptr |=> sfr_rdata == $past(ptr_r))
        else $error("pointer read mismatch");

    // ------------------------------------------------------------
    // Storage checks
    // ------------------------------------------------------------
    a_data_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd && sel_data |=> sfr_rdata == $past(coef_sel_rd))
        else $error("coefficient read mismatch");
    a_first_set_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd && sel_data && !ptr_r.converter_set_select |=>
        sfr_rdata == $past(coef_first_r[ptr_r.coefficient_index]))
        else $error("first set read mismatch");
    a_second_set_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd && sel_data && ptr_r.converter_set_select |=>
        sfr_rdata == $past(coef_second_r[ptr_r.coefficient_index]))
        else $error("second set read mismatch");
    a_first_set_write: assert property (@(posedge clk) disable iff (!rst_b)
        coef_wr && !ptr_r.converter_set_select |=>
        coef_first_r[$past(ptr_r.coefficient_index)] == $past(sfr_req.wdata))
        else $error("first set write lost");
    a_second_set_write: assert property (@(posedge clk) disable iff (!rst_b)
        coef_wr && ptr_r.converter_set_select |=>
        coef_second_r[$past(ptr_r.coefficient_index)] == $past(sfr_req.wdata))
        else $error("second set write lost");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !rd |=> sfr_rdata == 8'h00)
        else $error("read data not cleared");
    a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd && sel_none |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_first_offset: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> first_trim.offset ==
        $past({coef_first_r[`OFFSET_HIGH_LOC][5:0], coef_first_r[`OFFSET_LOW_LOC]}))
        else $error("first offset trim mismatch");
    a_first_gain: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> first_trim.gain ==
        $past({coef_first_r[`GAIN_HIGH_LOC][4:0], coef_first_r[`GAIN_LOW_LOC]}))
        else $error("first gain trim mismatch");
    a_second_offset: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> second_trim.offset ==
        $past({coef_second_r[`OFFSET_HIGH_LOC][5:0], coef_second_r[`OFFSET_LOW_LOC]}))
        else $error("second offset trim mismatch");
    a_second_gain: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> second_trim.gain ==
        $past({coef_second_r[`GAIN_HIGH_LOC][4:0], coef_second_r[`GAIN_LOW_LOC]}))
        else $error("second gain trim mismatch");
    a_trim_reset: assert property (@(posedge clk)
        !rst_b |=> first_trim == {`OFFSET_NEUTRAL, `GAIN_NEUTRAL} &&
        second_trim == {`OFFSET_NEUTRAL, `GAIN_NEUTRAL})
        else $error("trims not neutral after reset");

    // ------------------------------------------------------------
    // Window register and flag checks
    // ------------------------------------------------------------
    a_limit_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_lth |=> lt_high_r == $past(sfr_req.wdata))
        else $error("low limit high byte not written");
    a_ltl_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ltl |=> lt_low_r == $past(sfr_req.wdata))
        else $error("low limit low byte not written");
    a_gth_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_gth |=> gt_high_r == $past(sfr_req.wdata))
        else $error("high limit high byte not written");
    a_gtl_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_gtl |=> gt_low_r == $past(sfr_req.wdata))
        else $error("high limit low byte not written");
    a_limit_reset: assert property (@(posedge clk)
        !rst_b |=> lt_high_r == 8'h00)
        else $error("low limit high byte not reset");
    a_diff_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ctrl |=> diff_r == $past(sfr_req.wdata[`CTRL_DIFF_BIT]))
        else $error("differential bit not written");
    a_diff_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd && sel_ctrl |=> sfr_rdata[`CTRL_DIFF_BIT] == $past(diff_r))
        else $error("differential bit read mismatch");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        flag_r && !wr_ctrl |=> flag_r)
        else $error("window flag dropped without clear");
    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_b)
        flag_clear && !win_hit |=> !flag_r)
        else $error("window flag not cleared");
    a_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        win_hit |=> flag_r && window_hit_flag)
        else $error("window hit not latched");
    a_flag_cause: assert property (@(posedge clk) disable iff (!rst_b)
        !flag_r ##1 flag_r |-> $past(win_hit))
        else $error("flag set without a window hit");
    a_flag_polled: assert property (@(posedge clk) disable iff (!rst_b)
        rd && sel_ctrl |=> sfr_rdata[`CTRL_WIN_BIT] == $past(flag_r))
        else $error("window flag read mismatch");
endmodule

// >>> rtl/adc_cal_params.svh
/*
 Constants for the calibration port and window detector: register offsets,
 field positions, reset values and coefficient layout.
 Assumes inclusion by bare name from the package and the bench.
*/
`ifndef ADC_CAL_PARAMS_SVH
`define ADC_CAL_PARAMS_SVH

`define OFS_CAL_POINTER 8'h00ba
`define OFS_CAL_DATA 8'h00bb
`define OFS_HIGH_LIMIT_LOW 8'h00c4
`define OFS_HIGH_LIMIT_HIGH 8'h00c5
`define OFS_LOW_LIMIT_LOW 8'h00c6
`define OFS_LOW_LIMIT_HIGH 8'h00c7
`define OFS_CONV_CONTROL 8'h00e8

`define PTR_STEP_BIT 7
`define PTR_SEL_BIT 6
`define CTRL_WIN_BIT 1
`define CTRL_DIFF_BIT 0

`define PTR_RESET 8'h00d7
`define LIMIT_RESET 8'h0000
`define CTRL_RESET 8'h0000

`define COEF_DEPTH 64
`define OFFSET_LOW_LOC 6'h13
`define OFFSET_HIGH_LOC 6'h14
`define GAIN_LOW_LOC 6'h15
`define GAIN_HIGH_LOC 6'h16
`define OFFSET_NEUTRAL 14'h2000
`define GAIN_NEUTRAL 13'h1000

`endif

// >>> rtl/adc_cal_pkg.sv
/*
 Types shared by the calibration port and window detector.
 Assumes the constants header is on the include path.
*/
package adc_cal_pkg;
    `include "adc_cal_params.svh"

    typedef struct packed {
        logic pointer_auto_step;
        logic converter_set_select;
        logic [5:0] coefficient_index;
    } cal_pointer_t;

    typedef struct packed {
        logic en;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } conv_result_t;

    typedef struct packed {
        logic [13:0] offset;
        logic [12:0] gain;
    } cal_trim_t;
endpackage

// >>> rtl/window_compare.sv
/*
 Window comparator for first-converter results.
 Assumes results and limits are stable on the cycle that the result is valid.
*/
`timescale 1ns/10ps
module window_compare
    import adc_cal_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic diff_mode,
    input wire logic [15:0] high_limit,
    input wire logic [15:0] low_limit,
    input wire conv_result_t result,
    output logic hit
);
    wire logic [16:0] res_x;
    wire logic [16:0] gt_x;
    wire logic [16:0] lt_x;
    wire logic above;
    wire logic below;
    wire logic inside_mode;
    wire logic hit_comb;

    // Differential values are sign extended, single-ended ones zero extended.
    assign res_x = {diff_mode & result.word[15], result.word};
    assign gt_x = {diff_mode & high_limit[15], high_limit};
    assign lt_x = {diff_mode & low_limit[15], low_limit};
    assign above = $signed(res_x) > $signed(gt_x);
    assign below = $signed(res_x) < $signed(lt_x);
    assign inside_mode = $signed(lt_x) > $signed(gt_x);
    assign hit_comb = inside_mode ? (above & below) : (above | below);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hit <= 1'b0;
        end else begin
            hit <= result.valid & hit_comb;
        end
    end

    a_hit_cause: assert property (@(posedge clk) disable iff (!rst_b)
        hit |-> $past(result.valid))
        else $error("window hit without a conversion");
endmodule

// >>> verification/adc_cal_window_bench.sv
/*
 Self-checking bench for the calibration port and window detector.
 Assumes the package and constants header are compiled and on the include path.
*/
`timescale 1ns/10ps
`include "adc_cal_params.svh"
module adc_cal_window_bench;
    import adc_cal_pkg::*;
    logic clk;
    logic rst_b;
    sfr_req_t sfr_req;
    conv_result_t first_result;
    logic [7:0] sfr_rdata;
    logic window_hit_flag;
    logic diff_mode;
    cal_trim_t first_trim;
    cal_trim_t second_trim;
    int n_errors = 0;
    int compares = 0;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'h0000_0006;
    logic [31:0] v;
    logic [7:0] b[4];
    logic [32:0] cfg[4] = '{{1'b0, 16'h2000, 16'h1000}, {1'b0, 16'h1000, 16'h2000},
        {1'b1, 16'h1000, 16'hffff}, {1'b1, 16'hffff, 16'h1000}};
    logic [63:0] wds[4] = '{64'h1800_2000_1000_0fff, 64'h2001_0fff_1800_2000,
        64'h0000_ffff_1000_8000, 64'h8000_1001_0000_ffff};
    logic [3:0] hits[4] = '{4'b1000, 4'b1100, 4'b1000, 4'b1100};
    logic [15:0] w;
    logic e;

    adc_cal_window DUT (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .first_result(first_result), .window_hit_flag(window_hit_flag),
        .diff_mode(diff_mode), .first_trim(first_trim), .second_trim(second_trim));

    // ----------------------------------------------------------------
    // Clock, helpers and bus tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The request stays up after the edge; of the other tasks only idle and res lower it first.
    task automatic acc(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{1'b1, wr_en, a, d};
        @(posedge clk);
        #1;
    endtask

    task automatic idle();
        sfr_req.en = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        acc(1'b0, a, 8'h00);
    endtask

    task automatic lim(input logic [15:0] lt, input logic [15:0] gt);
        wr(`OFS_LOW_LIMIT_LOW, lt[7:0]);
        wr(`OFS_LOW_LIMIT_HIGH, lt[15:8]);
        wr(`OFS_HIGH_LIMIT_LOW, gt[7:0]);
        wr(`OFS_HIGH_LIMIT_HIGH, gt[15:8]);
    endtask

    task automatic res(input logic [15:0] word);
        sfr_req.en = 1'b0;
        first_result = '{1'b1, word};
        @(posedge clk);
        #1;
        first_result.valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Read data monitor
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rd_seen) begin
            check(sfr_rdata, exp_q.pop_front());
        end
        rd_seen <= sfr_req.en && !sfr_req.wr && rst_b;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        sfr_req = '0;
        first_result = '0;
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        rd(`OFS_CAL_POINTER, `PTR_RESET);
        rd(`OFS_LOW_LIMIT_HIGH, 8'h00);
        rd(`OFS_CONV_CONTROL, 8'h00);
        wr(8'h00, 8'h55);
        rd(8'h00, 8'h00);
        idle();
        check(first_trim, {`OFFSET_NEUTRAL, `GAIN_NEUTRAL});
        check(second_trim, {`OFFSET_NEUTRAL, `GAIN_NEUTRAL});
        for (int i = 0; i < 4; i++) begin
            v = xs();
            b[i] = v[7:0];
        end
        wr(`OFS_CAL_POINTER, 8'hbe);
        wr(`OFS_CAL_DATA, b[0]);
        wr(`OFS_CAL_DATA, b[1]);
        rd(`OFS_CAL_POINTER, 8'h80);
        wr(`OFS_CAL_POINTER, 8'hfe);
        wr(`OFS_CAL_DATA, b[2]);
        rd(`OFS_CAL_POINTER, 8'hff);
        wr(`OFS_CAL_POINTER, 8'h3e);
        rd(`OFS_CAL_DATA, b[0]);
        rd(`OFS_CAL_DATA, b[0]);
        rd(`OFS_CAL_POINTER, 8'h3e);
        wr(`OFS_CAL_POINTER, 8'h7e);
        rd(`OFS_CAL_DATA, b[2]);
        wr(`OFS_CAL_POINTER, 8'hbe);
        rd(`OFS_CAL_DATA, b[0]);
        rd(`OFS_CAL_DATA, b[1]);
        rd(`OFS_CAL_POINTER, 8'h80);
        for (int s = 0; s < 2; s++) begin
            wr(`OFS_CAL_POINTER, (s == 1) ? 8'hd3 : 8'h93);
            for (int i = 0; i < 4; i++) begin
                wr(`OFS_CAL_DATA, b[i]);
            end
            idle();
            check((s == 1) ? second_trim : first_trim,
                {b[1][5:0], b[0], b[3][4:0], b[2]});
        end
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 4; k++) begin
                w = wds[c][63 - 16 * k -: 16];
                e = hits[c][3 - k];
                wr(`OFS_CONV_CONTROL, {7'h00, cfg[c][32]});
                lim(cfg[c][31:16], cfg[c][15:0]);
                res(w);
                check(window_hit_flag, e);
                check(diff_mode, cfg[c][32]);
                rd(`OFS_CONV_CONTROL, {6'h00, e, cfg[c][32]});
            end
        end
        wr(`OFS_CONV_CONTROL, 8'h00);
        lim(16'h2000, 16'h1000);
        for (int i = 0; i < 6; i++) begin
            v = xs();
            wr(`OFS_CONV_CONTROL, 8'h00);
            res(v[15:0]);
            check(window_hit_flag, v[15:0] < 16'h2000 && v[15:0] > 16'h1000);
        end
        res(16'h1800);
        res(16'h3000);
        check(window_hit_flag, 1'b1);
        wr(`OFS_CONV_CONTROL, 8'h02);
        rd(`OFS_CONV_CONTROL, 8'h02);
        wr(`OFS_CONV_CONTROL, 8'h00);
        rd(`OFS_CONV_CONTROL, 8'h00);
        wr(`OFS_CONV_CONTROL, 8'h02);
        idle();
        idle();
        check(window_hit_flag, 1'b0);
        end_sim();
    end
endmodule
